// ===== rtl/adcc_core.sv
// Digital back end of a delta-sigma converter: correction, clipping,
// calibration, power-on hold, sleep and start pin conversion control.
// Assumes a decimation filter on i_clk and a host on a serial link clock.
// Overview of operation
// - Output equals (filter minus offset) times gain/unity
// - Output never exceeds the 24-bit code range
// - Offset word is 24-bit two's complement, zero neutral
// - Gain word is 24-bit unsigned, unity at one quarter of full scale
// - Words load by register write or calibration
// - Amplifier gain change reloads trimmed gain word
// - Calibration end drives done low, next data valid
// - Sleep request during calibration waits for its end
// - System gain calibration aborts conversion, updates gain
// - Internal offset calibration shorts inputs, updates offset
// - System offset calibration aborts conversion, updates offset
// - Calibration averages sixteen consecutive conversions
// - Calibration lasts 50 oscillator, 32 modulator, 16 data
// - Power-up holds logic reset 65536 clocks
// - Sleep entered by command or by start pin
// - Reference in sleep follows reference control field
// - Start pulse converts once, done low, then shutdown
// - Start-to-done delay follows the data rate
// - Start rising holds filter reset 32 modulator clocks
// - Start held high converts back to back
`timescale 1ns/1ps
`include "adcc_consts.svh"
module adcc_core import adcc_pkg::*; #(
  parameter int POR_CYCLES = `ADCC_POR_CYCLES,  // Shorten in simulation
  parameter int MOD_DIV = `ADCC_MOD_DIV,        // System clocks per modulator clock
  parameter logic [7:0][23:0] TRIM_GAIN = {8{`ADCC_UNITY_GAIN}}  // Per amplifier gain
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic i_start,
  input wire logic i_filt_valid,
  input wire logic [23:0] i_filt_data,
  output logic o_done_n,
  output logic [23:0] o_result,
  output logic o_filt_rst,
  output logic o_cal_short,
  output logic o_ref_on,
  output logic o_sleeping
);
  // ----------------------------------------------------------------
  // Derived counts
  // ----------------------------------------------------------------
  localparam int FRESET_CYCLES = `ADCC_FRESET_MODS * MOD_DIV;

  adcc_core_s st;        // Core state on i_clk
  adcc_core_s next_st;
  adcc_link_s lk;        // Serial state on i_sclk
  adcc_link_s next_lk;

  // ----------------------------------------------------------------
  // Serial link side
  // ----------------------------------------------------------------
  // Bytes arrive MSB first; a whole byte flips the toggle
  always_comb begin
    next_lk = lk;
    if (i_cs_n) begin
      // Deselected: realign on the next byte
      next_lk.cnt = 3'h0;
    end else begin
      next_lk.sh = {lk.sh[6:0], i_din};
      next_lk.cnt = lk.cnt + 3'h1;
      if (lk.cnt == 3'h7) begin
        next_lk.byte_q = {lk.sh[6:0], i_din};
        next_lk.tog = ~lk.tog;
      end
    end
  end

  // Held in reset with the rest of the logic during the power-on hold
  // The release is safe: the host keeps the link clock still until then
  always_ff @(posedge i_sclk or posedge st.link_rst) begin
    if (st.link_rst) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------
  // Correction datapath
  // ----------------------------------------------------------------
  logic signed [24:0] diff;    // Filter minus offset
  logic signed [49:0] prod;    // Times gain word
  logic signed [49:0] scaled;  // Divided by unity code
  logic [23:0] clipped;        // Saturated output code
  // Full-width product so the clip sees the true overflow
  always_comb begin
    diff = $signed({i_filt_data[23], i_filt_data}) - $signed({st.offset[23], st.offset});
    prod = diff * $signed({1'b0, st.gain});
    scaled = prod >>> `ADCC_GAIN_SHIFT;
    if (scaled > $signed({26'h0, `ADCC_CODE_POS})) begin
      clipped = `ADCC_CODE_POS;
    end else if (scaled < $signed({{26{1'b1}}, `ADCC_CODE_NEG})) begin
      clipped = `ADCC_CODE_NEG;
    end else begin
      clipped = scaled[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------------
  logic byte_ev;               // A new byte from the host
  logic start_rise;            // Settled start pin rising
  logic cal_fin;               // Calibration completes this cycle
  logic signed [27:0] sum;     // Sum including the last sample
  logic [23:0] avg;            // Calibration average
  logic [25:0] trial;          // Divide step remainder
  logic [45:0] quot_n;         // Quotient after the step
  always_comb begin
    next_st = st;
    cal_fin = 1'b0;
    sum = st.acc + 28'(signed'(i_filt_data));
    avg = sum[27:4];
    trial = {st.rem[24:0], st.num[45]};
    quot_n = {st.quot[44:0], 1'b0};
    // Three stage sync; a change counts when the last two agree
    // A late start edge costs one clock, never a false edge
    next_st.tg_s1 = lk.tog;
    next_st.tg_s2 = st.tg_s1;
    next_st.tg_s3 = st.tg_s2;
    next_st.sp_s1 = i_start;
    next_st.sp_s2 = st.sp_s1;
    next_st.sp_s3 = st.sp_s2;
    if (st.sp_s2 == st.sp_s3) begin
      next_st.start = st.sp_s3;
    end
    start_rise = (st.sp_s2 == st.sp_s3) && st.sp_s3 && !st.start;
    byte_ev = (st.tg_s2 == st.tg_s3) && (st.tg_s3 != st.tg_seen);
    if (byte_ev) begin
      next_st.tg_seen = st.tg_s3;
    end
    case (st.state)
      ST_POR: begin
        // All logic held until the count expires
        next_st.por_cnt = st.por_cnt + 17'h1;
        if (st.por_cnt == 17'(POR_CYCLES - 1)) begin
          next_st.state = ST_SLEEP;
          next_st.link_rst = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (start_rise) begin
          next_st.state = ST_FRESET;
          next_st.cnt = 16'h0;
          next_st.done_n = 1'b1;
        end
      end
      ST_FRESET: begin
        // Filter reset lets the analog side settle
        next_st.cnt = st.cnt + 16'h1;
        if (st.cnt == 16'(FRESET_CYCLES - 1)) begin
          next_st.state = ST_CONV;
        end
      end
      ST_CONV: begin
        // Conversion time is set by the filter's own data rate
        if (i_filt_valid) begin
          next_st.result = clipped;
          next_st.done_n = 1'b0;
          if (!st.start) begin
            next_st.state = ST_SLEEP;
          end                                          // else
        end
      end
      ST_CAL_WAIT: begin
        next_st.cnt = st.cnt + 16'h1;
        if (st.cnt == 16'(`ADCC_OSC_CAL_CYCLES - 1)) begin
          next_st.state = ST_CAL_FRESET;
          next_st.cnt = 16'h0;
        end
      end
      ST_CAL_FRESET: begin
        next_st.cnt = st.cnt + 16'h1;
        if (st.cnt == 16'(FRESET_CYCLES - 1)) begin
          next_st.state = ST_CAL_ACC;
          next_st.acc = 28'sh0;
          next_st.nacc = 5'h0;
        end
      end
      ST_CAL_ACC: begin
        if (i_filt_valid) begin
          next_st.acc = sum;
          next_st.nacc = st.nacc + 5'h1;
          if (st.nacc == 5'(`ADCC_CAL_SAMPLES - 1)) begin
            if (st.cal != CAL_SYS_GAIN) begin
              next_st.offset = avg;
              cal_fin = 1'b1;
            end else begin
              // Gain = unity * full scale / (average - offset)
              next_st.dvs = 25'($signed({avg[23], avg}) - $signed({st.offset[23], st.offset}));
              next_st.num = {`ADCC_CODE_POS, 22'h0};
              next_st.rem = 26'h0;
              next_st.quot = 46'h0;
              next_st.cnt = 16'h0;
              next_st.state = ST_CAL_DIV;
              if (next_st.dvs[24] || next_st.dvs == 25'h0) begin
                // Non-positive span: best effort is the largest gain
                next_st.gain = `ADCC_GAIN_MAX;
                cal_fin = 1'b1;
              end
            end
          end
        end
      end
      ST_CAL_DIV: begin
        // One restoring divide step per clock trades speed for area
        next_st.num = {st.num[44:0], 1'b0};
        if (trial >= {1'b0, st.dvs}) begin
          next_st.rem = trial - {1'b0, st.dvs};
          quot_n[0] = 1'b1;
        end else begin
          next_st.rem = trial;
        end
        next_st.quot = quot_n;
        next_st.cnt = st.cnt + 16'h1;
        if (st.cnt == 16'(`ADCC_DIV_STEPS - 1)) begin
          next_st.gain = (quot_n[45:24] != 22'h0) ? `ADCC_GAIN_MAX : quot_n[23:0];
          cal_fin = 1'b1;
        end
      end
      default: begin
        next_st.state = ST_POR;
      end
    endcase
    // Calibration end: done low, then sleep or keep converting
    if (cal_fin) begin
      next_st.done_n = 1'b0;
      next_st.cal_short = 1'b0;
      next_st.state = (st.pend_sleep || !st.start) ? ST_SLEEP : ST_CONV;
    end
    // Host bytes; the serial side is quiet during the power-on hold
    if (byte_ev && st.state != ST_POR) begin
      if (st.wr_pend) begin
        next_st.wr_pend = 1'b0;
        case (st.wr_idx)
          `ADCC_REG_OFS0: next_st.offset[7:0] = lk.byte_q;
          `ADCC_REG_OFS1: next_st.offset[15:8] = lk.byte_q;
          `ADCC_REG_OFS2: next_st.offset[23:16] = lk.byte_q;
          `ADCC_REG_GAIN0: next_st.gain[7:0] = lk.byte_q;
          `ADCC_REG_GAIN1: next_st.gain[15:8] = lk.byte_q;
          `ADCC_REG_GAIN2: next_st.gain[23:16] = lk.byte_q;
          `ADCC_REG_AMP: begin
            next_st.amp = lk.byte_q[2:0];
            if (lk.byte_q[2:0] != st.amp) begin
              next_st.gain = TRIM_GAIN[lk.byte_q[2:0]];
            end
          end
          default: next_st.ref_ctl = lk.byte_q[1:0];
        endcase
      end else if (lk.byte_q[7:4] == `ADCC_CMD_WRITE) begin
        next_st.wr_pend = 1'b1;
        next_st.wr_idx = lk.byte_q[2:0];
      end else if (lk.byte_q == `ADCC_CMD_SYS_GAIN || lk.byte_q == `ADCC_CMD_SYS_OFS ||
                   lk.byte_q == `ADCC_CMD_SELF_OFS) begin
        // Any running conversion is abandoned at once
        next_st.state = ST_CAL_WAIT;
        next_st.cnt = 16'h0;
        next_st.done_n = 1'b1;
        next_st.pend_sleep = 1'b0;
        next_st.cal = (lk.byte_q == `ADCC_CMD_SYS_GAIN) ? CAL_SYS_GAIN :
                      (lk.byte_q == `ADCC_CMD_SYS_OFS) ? CAL_SYS_OFS : CAL_SELF_OFS;
        next_st.cal_short = (lk.byte_q == `ADCC_CMD_SELF_OFS);
      end else if (lk.byte_q == `ADCC_CMD_SLEEP) begin
        if (st.state inside {ST_CAL_WAIT, ST_CAL_FRESET, ST_CAL_ACC, ST_CAL_DIV}) begin
          next_st.pend_sleep = 1'b1;
        end else begin
          next_st.state = ST_SLEEP;
        end
      end
    end
    // Levels that follow the state
    next_st.sleeping = (next_st.state == ST_SLEEP);
    next_st.filt_rst = next_st.state inside {ST_POR, ST_SLEEP, ST_FRESET, ST_CAL_WAIT,
                                             ST_CAL_FRESET};
    next_st.ref_on = (next_st.ref_ctl == `ADCC_REF_ALWAYS) ||
                     (next_st.ref_ctl == `ADCC_REF_AWAKE && !next_st.sleeping);
  end

  // Register the whole core state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
      st.state <= ST_POR;
      st.offset <= `ADCC_OFFSET_RST;
      st.gain <= TRIM_GAIN[0];
      st.done_n <= 1'b1;
      st.filt_rst <= 1'b1;
      st.link_rst <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_done_n = st.done_n;
  assign o_result = st.result;
  assign o_filt_rst = st.filt_rst;
  assign o_cal_short = st.cal_short;
  assign o_ref_on = st.ref_on;
  assign o_sleeping = st.sleeping;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic in_cal;   // Any calibration state
  assign in_cal = st.state inside {ST_CAL_WAIT, ST_CAL_FRESET, ST_CAL_ACC, ST_CAL_DIV};

  // Host bytes change the plan mid-cycle, so most checks skip those cycles
  conv_result_a: assert property (st.state == ST_CONV && i_filt_valid && !byte_ev
    && i_filt_data == st.offset |=> o_result == 24'h0 && !o_done_n)
    else $error("neutral input did not give zero");
  clip_pos_a: assert property (st.state == ST_CONV && i_filt_valid && !byte_ev
    && scaled > 50'sh7fffff |=> o_result == `ADCC_CODE_POS)
    else $error("positive overflow not saturated");
  // Negative overflow mirrors the positive clip
  clip_neg_a: assert property (st.state == ST_CONV && i_filt_valid && !byte_ev
    && scaled < -50'sh800000 |=> o_result == `ADCC_CODE_NEG)
    else $error("negative overflow not saturated");
  por_hold_a: assert property ($fell(st.state == ST_POR)
    |-> $past(st.por_cnt) == 17'(POR_CYCLES - 1) && !st.link_rst)
    else $error("power-on hold length wrong");
  freset_len_a: assert property ($fell(st.state == ST_FRESET) && !$past(byte_ev)
    |-> $past(st.cnt) == 16'(FRESET_CYCLES - 1) && $past(o_filt_rst))
    else $error("filter reset hold length wrong");
  // Settle wait ahead of the calibration filter reset
  cal_wait_a: assert property ($fell(st.state == ST_CAL_WAIT) && !$past(byte_ev)
    |-> $past(st.cnt) == 16'(`ADCC_OSC_CAL_CYCLES - 1) && o_filt_rst)
    else $error("calibration settle wait length wrong");
  cal_avg_a: assert property ($fell(st.state == ST_CAL_ACC) && st.state != ST_CAL_WAIT
    |-> $past(st.nacc) == 5'(`ADCC_CAL_SAMPLES - 1))
    else $error("calibration left before sixteen samples");
  cal_done_a: assert property ($fell(in_cal) && !$past(byte_ev) |-> !o_done_n)
    else $error("calibration end did not drive done low");
  cal_sleep_a: assert property ($fell(in_cal) && $past(st.pend_sleep) && !$past(byte_ev)
    |-> o_sleeping)
    else $error("pending sleep not taken after calibration");
  gain_reload_a: assert property (st.amp != $past(st.amp) |-> st.gain == TRIM_GAIN[st.amp])
    else $error("gain word not reloaded on amplifier change");
  single_conv_a: assert property (st.state == ST_CONV && i_filt_valid && !st.start
    && !byte_ev |=> o_sleeping && !o_done_n ##1 o_sleeping)
    else $error("single conversion did not shut down");
  continuous_a: assert property (st.state == ST_CONV && i_filt_valid && st.start
    && !byte_ev |=> st.state == ST_CONV)
    else $error("continuous conversion stopped");
  self_short_a: assert property (o_cal_short |-> in_cal && st.cal == CAL_SELF_OFS)
    else $error("inputs shorted outside internal offset calibration");
  // In sleep only the always-on setting keeps the reference up
  ref_sleep_a: assert property (o_sleeping |-> o_ref_on
    == (st.ref_ctl == `ADCC_REF_ALWAYS))
    else $error("reference level in sleep wrong");

  // Covers for the main flows
  cal_gain_c: cover property (st.state == ST_CAL_DIV ##1 $fell(in_cal));
  single_c: cover property (st.state == ST_CONV && i_filt_valid && !st.start);
  back_to_back_c: cover property (st.state == ST_CONV && i_filt_valid ##1 st.state == ST_CONV);
  clip_neg_c: cover property (st.state == ST_CONV && i_filt_valid && clipped == `ADCC_CODE_NEG);
  sleep_cal_c: cover property ($fell(in_cal) && $past(st.pend_sleep) && o_sleeping);
endmodule

// ===== include/adcc_consts.svh
// Constants of the converter control block: offsets, codes and counts.
// Assumes inclusion by bare name from the package and the core module.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
// ----------------------------------------------------------------
// Correction arithmetic
// ----------------------------------------------------------------
`define ADCC_UNITY_GAIN 24'h400000
`define ADCC_GAIN_SHIFT 22
`define ADCC_CODE_POS 24'h7fffff
`define ADCC_CODE_NEG 24'h800000
`define ADCC_OFFSET_RST 24'h000000
`define ADCC_GAIN_MAX 24'hffffff
// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define ADCC_POR_CYCLES 65536
`define ADCC_OSC_CAL_CYCLES 50
`define ADCC_FRESET_MODS 32
`define ADCC_MOD_DIV 16
`define ADCC_CAL_SAMPLES 16
`define ADCC_CAL_SHIFT 4
`define ADCC_DIV_STEPS 46
// ----------------------------------------------------------------
// Command bytes and register indices
// ----------------------------------------------------------------
`define ADCC_CMD_SLEEP 8'h02
`define ADCC_CMD_SYS_OFS 8'h60
`define ADCC_CMD_SYS_GAIN 8'h61
`define ADCC_CMD_SELF_OFS 8'h62
`define ADCC_CMD_WRITE 4'h4
`define ADCC_REG_OFS0 3'h0
`define ADCC_REG_OFS1 3'h1
`define ADCC_REG_OFS2 3'h2
`define ADCC_REG_GAIN0 3'h3
`define ADCC_REG_GAIN1 3'h4
`define ADCC_REG_GAIN2 3'h5
`define ADCC_REG_AMP 3'h6
`define ADCC_REG_MUX2 3'h7
// Reference control field values
`define ADCC_REF_OFF 2'h0
`define ADCC_REF_ALWAYS 2'h1
`define ADCC_REF_AWAKE 2'h2
`endif

// ===== include/adcc_pkg.sv
// Types of the converter control block: states and the state records.
// Assumes the constants header sits in the include path.
package adcc_pkg;
  `include "adcc_consts.svh"
  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_POR, ST_SLEEP, ST_FRESET, ST_CONV, ST_CAL_WAIT, ST_CAL_FRESET, ST_CAL_ACC, ST_CAL_DIV
  } adcc_state_e;
  typedef enum logic [1:0] {CAL_SYS_GAIN, CAL_SYS_OFS, CAL_SELF_OFS} adcc_cal_e;
  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    adcc_state_e state;
    logic [16:0] por_cnt;      // Power-on hold counter
    logic [15:0] cnt;          // Wait and divide step counter
    adcc_cal_e cal;            // Calibration in progress
    logic pend_sleep;          // Sleep requested during calibration
    logic [23:0] offset;       // Offset correction word
    logic [23:0] gain;         // Gain correction word
    logic [2:0] amp;           // Amplifier gain setting
    logic [1:0] ref_ctl;       // Reference control field
    logic wr_pend;             // Next byte is register data
    logic [2:0] wr_idx;        // Target register of that data
    logic tg_s1, tg_s2, tg_s3, tg_seen;  // Byte event synchroniser
    logic sp_s1, sp_s2, sp_s3, start;    // Start pin synchroniser
    logic signed [27:0] acc;   // Calibration sum
    logic [4:0] nacc;          // Samples summed
    logic [45:0] num;          // Dividend shifter
    logic [25:0] rem;          // Partial remainder
    logic [45:0] quot;         // Quotient shifter
    logic [24:0] dvs;          // Divisor
    logic [23:0] result;       // Latest corrected output
    logic done_n;              // Serial out / done pin level
    logic filt_rst;            // Filter held in reset
    logic cal_short;           // Inputs disconnected, zero applied
    logic ref_on;              // Internal reference powered
    logic sleeping;            // Low power state
    logic link_rst;            // Serial side held in reset
  } adcc_core_s;
  typedef struct packed {
    logic [2:0] cnt;           // Bit position in the byte
    logic [7:0] sh;            // Incoming bits
    logic [7:0] byte_q;        // Last whole byte, held for the core
    logic tog;                 // Flips once per whole byte
  } adcc_link_s;
endpackage

// ===== sim/adcc_host.sv
// Host side of the serial command link: sends whole bytes, MSB first.
// Assumes the bench calls send_byte only after the power-on hold is over.
`timescale 1ns/1ps
module adcc_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  // ----------------------------------------------------------------
  // Link clock and byte framing
  // ----------------------------------------------------------------
  // Idle: clock still, deselected
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // One byte at a 30 ns link clock; clock runs only inside the frame
  task automatic send_byte(input logic [7:0] b);
    int i;
    #7;
    o_cs_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      o_din = b[i];
      #15 o_sclk = 1'b1;
      #15 o_sclk = 1'b0;
    end
    #15 o_cs_n = 1'b1;
    // Released line: no pull, so show the inverse of the last bit
    o_din = ~o_din;
    // Gap keeps bytes slower than the core's byte crossing
    #1000;
  endtask
endmodule

// ===== sim/adcc_core_tb.sv
// Self-checking bench for the converter control core.
// Assumes the core, its package and the host model are compiled first.
`timescale 1ns/1ps
`include "adcc_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module adcc_core_tb;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int POR = 64;  // Short power-on hold
  localparam int MODD = 2;  // Short modulator divide
  // Amplifier setting 1 has its own trimmed gain of one half
  localparam logic [7:0][23:0] TRIM = {{6{24'h400000}}, 24'h200000, 24'h400000};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_start = 1'b0;
  logic i_filt_valid = 1'b0;
  logic [23:0] i_filt_data = 24'h000000;
  logic sclk, cs_n, din, o_done_n, o_filt_rst, o_cal_short, o_ref_on, o_sleeping;
  logic [23:0] o_result;
  int n_errors = 0;
  int comparisons = 0;
  int n;
  // System clock, 100 ns
  always #50 i_clk = ~i_clk;
  adcc_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  adcc_core #(.POR_CYCLES(POR), .MOD_DIV(MODD), .TRIM_GAIN(TRIM)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .i_start(i_start), .i_filt_valid(i_filt_valid), .i_filt_data(i_filt_data),
    .o_done_n(o_done_n), .o_result(o_result), .o_filt_rst(o_filt_rst),
    .o_cal_short(o_cal_short), .o_ref_on(o_ref_on), .o_sleeping(o_sleeping));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("Errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Bounded wait: 0 filter reset, 1 done, 2 sleeping
  task automatic wait_sig(input int sel, input logic v);
    int i;
    logic s;
    for (i = 0; i < 600; i++) begin
      @(posedge i_clk);
      #1;
      s = (sel == 0) ? o_filt_rst : (sel == 1) ? o_done_n : o_sleeping;
      if (s === v) return;
    end
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    finish_test;
  endtask
  // Register write: command byte then data byte
  task automatic wr(input logic [2:0] idx, input logic [7:0] v);
    host_u.send_byte({`ADCC_CMD_WRITE, 1'b0, idx});
    host_u.send_byte(v);
  endtask
  task automatic wr24(input logic [2:0] base, input logic [23:0] v);
    wr(base, v[7:0]);
    wr(base + 3'h1, v[15:8]);
    wr(base + 3'h2, v[23:16]);
  endtask
  // One filter sample pulse
  task automatic pulse(input logic [23:0] d);
    @(posedge i_clk) begin
      i_filt_valid <= 1'b1;
      i_filt_data <= d;
    end
    @(posedge i_clk) i_filt_valid <= 1'b0;
  endtask
  // Sample in, corrected result and done checked once settled
  task automatic conv(input logic [23:0] d, input logic [23:0] exp);
    pulse(d);
    @(negedge i_clk);
    `CHK(o_result, exp)
    `CHK(o_done_n, 1'b0)
  endtask
  // Start pin rise; counts clocks of filter reset after waking
  task automatic rise(output int cnt);
    cnt = 0;
    @(posedge i_clk) i_start <= 1'b1;
    wait_sig(2, 1'b0);
    while (o_filt_rst === 1'b1 && cnt < 1000) begin
      @(posedge i_clk);
      #1;
      cnt++;
    end
    if (cnt >= 1000) begin
      n_errors++;
      $display("BAD %0t filter reset ran long", $time);
      finish_test;
    end
  endtask
  task automatic fall;
    @(posedge i_clk) i_start <= 1'b0;
    // Let the pin synchroniser settle before the next sample
    repeat (6) @(posedge i_clk);
  endtask
  // Calibration with samples alternating d and d+2, so the mean is d+1
  task automatic cal(input logic [7:0] cmd, input logic [23:0] d, input logic slp);
    int i;
    host_u.send_byte(cmd);
    `CHK(o_done_n, 1'b1)
    `CHK(o_cal_short, (cmd === `ADCC_CMD_SELF_OFS))
    wait_sig(0, 1'b0);
    // Optional sleep request while the samples are still to come
    if (slp) host_u.send_byte(`ADCC_CMD_SLEEP);
    for (i = 0; i < 16; i++) begin
      pulse(d + (i[0] ? 24'h000002 : 24'h000000));
    end
    wait_sig(1, 1'b0);
    `CHK(o_cal_short, 1'b0)
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    // No link traffic until the hold is over
    repeat (POR + 5) @(posedge i_clk);
    #1;
    `CHK(o_sleeping, 1'b1)
    `CHK(o_done_n, 1'b1)
    wr24(`ADCC_REG_OFS0, 24'h000010);
    rise(n);
    `CHK(n, `ADCC_FRESET_MODS * MODD)
    fall();
    conv(24'h000110, 24'h000100);
    `CHK(o_sleeping, 1'b1)
    // Start raised before touching configuration
    rise(n);
    wr24(`ADCC_REG_GAIN0, 24'h800000);
    conv(24'h600000, 24'h7fffff);
    conv(24'ha00000, 24'h800000);
    `CHK(o_sleeping, 1'b0)
    wr(`ADCC_REG_AMP, 8'h01);
    conv(24'h000210, 24'h000100);
    fall();
    // Start low through the whole calibration: sleep only afterwards
    cal(`ADCC_CMD_SELF_OFS, 24'h00001f, 1'b0);
    `CHK(o_sleeping, 1'b1)
    rise(n);
    conv(24'h000120, 24'h000080);
    // Host waits for each calibration; only a sleep request may cut in
    cal(`ADCC_CMD_SYS_GAIN, 24'h40001f, 1'b1);
    `CHK(o_sleeping, 1'b1)
    fall();
    rise(n);
    conv(24'h400020, 24'h7fffff);
    cal(`ADCC_CMD_SYS_OFS, 24'h00002f, 1'b0);
    conv(24'h000130, 24'h0001ff);
    wr(`ADCC_REG_MUX2, 8'h02);
    `CHK(o_ref_on, 1'b1)
    host_u.send_byte(`ADCC_CMD_SLEEP);
    `CHK(o_sleeping, 1'b1)
    `CHK(o_ref_on, 1'b0)
    wr(`ADCC_REG_MUX2, 8'h01);
    `CHK(o_ref_on, 1'b1)
    finish_test;
  end
endmodule
